// ==== logic/bcr_channel_regs.sv ====
// Contract
// [RULE1] falling change slew codes 0-4, rest reserved
// [RULE2] rising change slew adds 40 mV/us code
// [RULE3] bit 0 enables channel, resets off
// [RULE4] shut-down ramps at its slew; 7 is immediate
// [RULE5] start-up ramps at its slew, codes 0-5
// [RULE6] switch node pulled down while off unless disabled
// [RULE7] threshold 6.5 A plus 1 A/code; F disables
// [RULE8] max voltage code is read-only, reads 0xbe
// [RULE9] voltage code 0x1e..0xbe in 10 mV steps
// [RULE10] out-of-range point A voltage writes are dropped
// [RULE11] selector picks point A or point B
// [RULE12] two-bit mode: pfm, pwm full, pwm shed, auto
// [RULE13] configuration pin preloads fields when enabled
// [RULE14] point A voltage resets to 1.0 V
// [RULE15] point B voltage at 0x26, same rules
// [RULE16] voltage changes ramp at matching direction slew
`default_nettype none
module bcr_channel_regs
	import bcr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary bus address
)
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n,
	input  wire logic       configuration_pin_pin_en,
	input  wire bcr_configuration_pin_t  configuration_pin_init,
	output logic            channel_enable,
	output logic            regulating,
	output logic            ramping,
	output logic      [7:0] vout_code,
	output logic            switch_node_pulldown,
	output bcr_mode_t       active_mode,
	output logic      [3:0] overcurrent_threshold_code,
	output logic      [7:0] ocp_limit_deci_amps,
	output logic            ocp_limit_off
);
	typedef enum logic [3:0] {
		I_IDLE      = 4'b0000,
		I_ADDR      = 4'b0001,
		I_ADDR_ACK  = 4'b0010,
		I_PTR       = 4'b0011,
		I_PTR_ACK   = 4'b0100,
		I_WDATA     = 4'b0101,
		I_WDATA_ACK = 4'b0110,
		I_RDATA     = 4'b0111,
		I_RDATA_ACK = 4'b1000
	} bcr_istate_t;

	typedef struct packed {
		bcr_regs_t   regs;
		logic        loaded;
		logic [2:0]  scl_s;
		logic [2:0]  sda_s;
		bcr_istate_t st;
		logic [3:0]  cnt;
		logic [7:0]  rxsh;
		logic [7:0]  txsh;
		logic [7:0]  ptr;
		logic        rw;
		logic        nack;
		logic        drive_low;
	} bcr_state_t;

	bcr_state_t q_ff;
	bcr_state_t nxt_q;
	logic [7:0] target_code;

	function automatic logic in_range(input logic [7:0] v);
		in_range = (v >= VCODE_MIN) && (v <= VCODE_MAX); // [RULE9]
	endfunction

	// register read view; reserved bits and unmapped offsets read 0
	function automatic logic [7:0] reg_rd(input bcr_regs_t r,
		input logic [7:0] a);
		reg_rd = 8'h00;
		case (a)
			OFS_RAMP_ON:
			begin
				reg_rd[FALL_LSB +: 3] = r.fall_change_slew;
				reg_rd[RISE_LSB +: 3] = r.rise_change_slew;
				reg_rd[ON_BIT] = r.channel_on;
			end
			OFS_PWR_SLEW:
			begin
				reg_rd[PDN_LSB +: 3] = r.power_down_slew;
				reg_rd[PUP_LSB +: 3] = r.power_up_slew;
				reg_rd[PDOFF_BIT] = r.switch_node_pulldown_off;
			end
			OFS_OCP:
				reg_rd[3:0] = r.overcurrent_threshold_code;
			OFS_VMAX:
				reg_rd = VMAX_CODE; // [RULE8]
			OFS_SEL_MODES:
			begin
				reg_rd[SEL_BIT] = r.operating_point_select;
				reg_rd[MODEB_LSB +: 2] = r.point_b_mode;
				reg_rd[MODEA_LSB +: 2] = r.point_a_mode;
			end
			OFS_POINT_A:
				reg_rd = r.point_a_voltage_code;
			OFS_POINT_B:
				reg_rd = r.point_b_voltage_code;
			default:
				reg_rd = 8'h00;
		endcase
	endfunction

	// register write; unmapped and read-only offsets are ignored
	function automatic bcr_regs_t reg_wr(input bcr_regs_t r,
		input logic [7:0] a, input logic [7:0] d);
		reg_wr = r;
		case (a)
			OFS_RAMP_ON:
			begin
				reg_wr.fall_change_slew = d[FALL_LSB +: 3]; // [RULE1]
				reg_wr.rise_change_slew = d[RISE_LSB +: 3]; // [RULE2]
				reg_wr.channel_on = d[ON_BIT]; // [RULE3]
			end
			OFS_PWR_SLEW:
			begin
				reg_wr.power_down_slew = d[PDN_LSB +: 3]; // [RULE4]
				reg_wr.power_up_slew = d[PUP_LSB +: 3]; // [RULE5]
				reg_wr.switch_node_pulldown_off = d[PDOFF_BIT]; // [RULE6]
			end
			OFS_OCP:
				reg_wr.overcurrent_threshold_code = d[3:0]; // [RULE7]
			OFS_SEL_MODES:
			begin
				reg_wr.operating_point_select = d[SEL_BIT]; // [RULE11]
				reg_wr.point_b_mode = d[MODEB_LSB +: 2]; // [RULE12]
				reg_wr.point_a_mode = d[MODEA_LSB +: 2]; // [RULE12]
			end
			OFS_POINT_A:
				if (in_range(d))
					reg_wr.point_a_voltage_code = d; // [RULE10]
			OFS_POINT_B:
				if (in_range(d))
					reg_wr.point_b_voltage_code = d; // [RULE15]
			default:
				reg_wr = r; // includes the max voltage code, [RULE8]
		endcase
	endfunction

	function automatic bcr_mode_t mode_decode(input logic [1:0] m);
		mode_decode = '0;
		unique case (m)
			MODE_PFM:      mode_decode.force_pfm = 1'b1; // [RULE12]
			MODE_PWM_FULL: mode_decode.force_pwm_full = 1'b1;
			MODE_PWM_SHED: mode_decode.force_pwm_shed = 1'b1;
			MODE_AUTO:     mode_decode.auto_mode = 1'b1;
		endcase
	endfunction

	// serial slave: sample on scl rise, change sda on scl fall
	always_comb
	begin
		logic scl;
		logic scl_q;
		logic sda;
		logic sda_q;
		logic rise;
		logic fall;
		logic [7:0] rd;
		nxt_q = q_ff;
		scl = q_ff.scl_s[1];
		scl_q = q_ff.scl_s[2];
		sda = q_ff.sda_s[1];
		sda_q = q_ff.sda_s[2];
		rise = scl && !scl_q;
		fall = !scl && scl_q;
		rd = reg_rd(q_ff.regs, q_ff.ptr);
		nxt_q.scl_s = {q_ff.scl_s[1:0], scl_i};
		nxt_q.sda_s = {q_ff.sda_s[1:0], sda_i};
		if (scl && scl_q && !sda && sda_q)
		begin
			// start or repeated start restarts address phase
			nxt_q.st = I_ADDR;
			nxt_q.cnt = 4'h0;
			nxt_q.drive_low = 1'b0;
		end
		else if (scl && scl_q && sda && !sda_q)
		begin
			nxt_q.st = I_IDLE;
			nxt_q.drive_low = 1'b0;
		end
		else
		begin
			unique case (q_ff.st)
				I_IDLE:
					nxt_q.cnt = 4'h0;
				I_ADDR, I_PTR, I_WDATA:
					if (rise)
					begin
						nxt_q.rxsh = {q_ff.rxsh[6:0], sda};
						nxt_q.cnt = q_ff.cnt + 4'h1;
					end
					else if (fall && q_ff.cnt == 4'h8)
					begin
						nxt_q.cnt = 4'h0;
						nxt_q.drive_low = 1'b1;
						if (q_ff.st == I_ADDR)
						begin
							nxt_q.rw = q_ff.rxsh[0];
							if (q_ff.rxsh[7:1] == DEV_ADDR)
								nxt_q.st = I_ADDR_ACK;
							else
							begin
								// not ours: stay off the wire
								nxt_q.st = I_IDLE;
								nxt_q.drive_low = 1'b0;
							end
						end
						else if (q_ff.st == I_PTR)
						begin
							nxt_q.ptr = q_ff.rxsh;
							nxt_q.st = I_PTR_ACK;
						end
						else
						begin
							nxt_q.regs = reg_wr(q_ff.regs, q_ff.ptr,
								q_ff.rxsh);
							nxt_q.ptr = q_ff.ptr + 8'h01;
							nxt_q.st = I_WDATA_ACK;
						end
					end
				I_ADDR_ACK, I_PTR_ACK, I_WDATA_ACK:
					if (fall)
					begin
						nxt_q.cnt = 4'h0;
						nxt_q.drive_low = 1'b0;
						if (q_ff.st == I_ADDR_ACK && q_ff.rw)
						begin
							nxt_q.txsh = rd;
							nxt_q.drive_low = !rd[7];
							nxt_q.st = I_RDATA;
						end
						else if (q_ff.st == I_ADDR_ACK)
							nxt_q.st = I_PTR;
						else
							nxt_q.st = I_WDATA;
					end
				I_RDATA:
					if (rise)
						nxt_q.cnt = q_ff.cnt + 4'h1;
					else if (fall && q_ff.cnt == 4'h8)
					begin
						// release for the master's acknowledge
						nxt_q.drive_low = 1'b0;
						nxt_q.ptr = q_ff.ptr + 8'h01;
						nxt_q.cnt = 4'h0;
						nxt_q.st = I_RDATA_ACK;
					end
					else if (fall)
					begin
						nxt_q.txsh = {q_ff.txsh[6:0], 1'b0};
						nxt_q.drive_low = !q_ff.txsh[6];
					end
				I_RDATA_ACK:
					if (rise)
						nxt_q.nack = sda;
					else if (fall && q_ff.nack)
						nxt_q.st = I_IDLE;
					else if (fall)
					begin
						nxt_q.txsh = rd;
						nxt_q.drive_low = !rd[7];
						nxt_q.st = I_RDATA;
					end
			endcase
		end
		// one-shot preload in the first clock after reset release
		if (!q_ff.loaded)
		begin
			nxt_q.loaded = 1'b1;
			if (configuration_pin_pin_en) // [RULE13]
			begin
				nxt_q.regs.channel_on = configuration_pin_init.channel_on;
				nxt_q.regs.operating_point_select =
					configuration_pin_init.operating_point_select;
				nxt_q.regs.point_b_mode = configuration_pin_init.point_b_mode;
				nxt_q.regs.point_a_mode = configuration_pin_init.point_a_mode;
				if (in_range(configuration_pin_init.point_a_voltage_code))
					nxt_q.regs.point_a_voltage_code =
						configuration_pin_init.point_a_voltage_code;
			end
		end
	end

	// all state in one register; reset gives the documented values
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q_ff <= '0;
			q_ff.regs <= REGS_RESET; // [RULE14] [RULE15]
			q_ff.scl_s <= 3'h7;
			q_ff.sda_s <= 3'h7;
			q_ff.st <= I_IDLE;
		end
		else
			q_ff <= nxt_q;
	end

	// selected operating point drives the ramp target and the mode
	assign target_code = q_ff.regs.operating_point_select ?
		q_ff.regs.point_b_voltage_code :
		q_ff.regs.point_a_voltage_code; // [RULE11]
	assign active_mode = mode_decode(q_ff.regs.operating_point_select ?
		q_ff.regs.point_b_mode : q_ff.regs.point_a_mode); // [RULE11]

	bcr_ramp u_ramp (
		.sys_clk          (sys_clk),
		.rst_n            (rst_n),
		.channel_on       (q_ff.regs.channel_on),
		.target_code      (target_code),
		.rise_change_slew (q_ff.regs.rise_change_slew),
		.fall_change_slew (q_ff.regs.fall_change_slew),
		.power_up_slew    (q_ff.regs.power_up_slew),
		.power_down_slew  (q_ff.regs.power_down_slew),
		.vout_code        (vout_code),
		.regulating       (regulating),
		.ramping          (ramping)
	);

	// open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_n = !q_ff.drive_low;
	assign channel_enable = q_ff.regs.channel_on; // [RULE3]
	// pull-down only once the ramp has fully finished shutting down
	assign switch_node_pulldown = !regulating &&
		!q_ff.regs.switch_node_pulldown_off; // [RULE6]
	assign overcurrent_threshold_code = q_ff.regs.overcurrent_threshold_code;
	assign ocp_limit_off = (overcurrent_threshold_code == OCP_DISABLE);
	// reserved code 0 and disable both report zero amps
	assign ocp_limit_deci_amps =
		(overcurrent_threshold_code == OCP_RESERVED || ocp_limit_off) ?
		8'h00 : OCP_BASE_DA + OCP_STEP_DA *
		({4'h0, overcurrent_threshold_code} - 8'h01); // [RULE7]

endmodule
`default_nettype wire

// ==== logic/bcr_pkg.sv ====
`default_nettype none
package bcr_pkg;

	// register offsets
	localparam logic [7:0] OFS_RAMP_ON    = 8'h20;
	localparam logic [7:0] OFS_PWR_SLEW   = 8'h21;
	localparam logic [7:0] OFS_OCP        = 8'h22;
	localparam logic [7:0] OFS_VMAX       = 8'h23;
	localparam logic [7:0] OFS_SEL_MODES  = 8'h24;
	localparam logic [7:0] OFS_POINT_A    = 8'h25;
	localparam logic [7:0] OFS_POINT_B    = 8'h26;

	// field positions inside the 8-bit registers
	localparam int FALL_LSB   = 4;
	localparam int RISE_LSB   = 1;
	localparam int ON_BIT     = 0;
	localparam int PDN_LSB    = 4;
	localparam int PUP_LSB    = 1;
	localparam int PDOFF_BIT  = 0;
	localparam int SEL_BIT    = 4;
	localparam int MODEB_LSB  = 2;
	localparam int MODEA_LSB  = 0;

	// values after reset
	localparam logic [2:0] SLEW_RESET  = 3'h4;
	localparam logic [3:0] OCP_RESET   = 4'h9;
	localparam logic [7:0] VMAX_CODE   = 8'hbe;
	localparam logic [7:0] VOUT_RESET  = 8'h64;
	localparam logic [1:0] MODE_RESET  = 2'h3;

	// voltage code range, 10 mV per code
	localparam logic [7:0] VCODE_MIN   = 8'h1e;
	localparam logic [7:0] VCODE_MAX   = 8'hbe;

	// slew code limits and special codes
	localparam logic [2:0] SLEW_TOP_FALL  = 3'h4;
	localparam logic [2:0] SLEW_TOP_RISE  = 3'h5;
	localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;

	// over-current threshold in tenths of an ampere
	localparam logic [3:0] OCP_RESERVED = 4'h0;
	localparam logic [3:0] OCP_DISABLE  = 4'hf;
	localparam logic [7:0] OCP_BASE_DA  = 8'h41;
	localparam logic [7:0] OCP_STEP_DA  = 8'h0a;

	// mode encodings
	localparam logic [1:0] MODE_PFM      = 2'h0;
	localparam logic [1:0] MODE_PWM_FULL = 2'h1;
	localparam logic [1:0] MODE_PWM_SHED = 2'h2;
	localparam logic [1:0] MODE_AUTO     = 2'h3;

	// timing: slew step intervals derived from the 40 MHz clock
	localparam int CLK_PERIOD_PS = 25000;
	localparam int US_PS         = 1000000;
	localparam int CYC_PER_US    = US_PS / CLK_PERIOD_PS;
	localparam logic [8:0] CYC_8US = 9'(8 * CYC_PER_US);
	localparam logic [8:0] CYC_4US = 9'(4 * CYC_PER_US);
	localparam logic [8:0] CYC_2US = 9'(2 * CYC_PER_US);
	localparam logic [8:0] CYC_1US = 9'(1 * CYC_PER_US);

	// software-visible register contents
	typedef struct packed {
		logic [2:0] fall_change_slew;
		logic [2:0] rise_change_slew;
		logic       channel_on;
		logic [2:0] power_down_slew;
		logic [2:0] power_up_slew;
		logic       switch_node_pulldown_off;
		logic [3:0] overcurrent_threshold_code;
		logic       operating_point_select;
		logic [1:0] point_b_mode;
		logic [1:0] point_a_mode;
		logic [7:0] point_a_voltage_code;
		logic [7:0] point_b_voltage_code;
	} bcr_regs_t;

	localparam bcr_regs_t REGS_RESET = '{
		fall_change_slew:           SLEW_RESET,
		rise_change_slew:           SLEW_RESET,
		channel_on:                 1'b0,
		power_down_slew:            SLEW_RESET,
		power_up_slew:              SLEW_RESET,
		switch_node_pulldown_off:   1'b0,
		overcurrent_threshold_code: OCP_RESET,
		operating_point_select:     1'b0,
		point_b_mode:               MODE_RESET,
		point_a_mode:               MODE_RESET,
		point_a_voltage_code:       VOUT_RESET,
		point_b_voltage_code:       VOUT_RESET
	};

	// start-up values from the configuration pin
	typedef struct packed {
		logic       channel_on;
		logic       operating_point_select;
		logic [1:0] point_b_mode;
		logic [1:0] point_a_mode;
		logic [7:0] point_a_voltage_code;
	} bcr_configuration_pin_t;

	// decoded operating mode, one-hot
	typedef struct packed {
		logic force_pfm;
		logic force_pwm_full;
		logic force_pwm_shed;
		logic auto_mode;
	} bcr_mode_t;

endpackage
`default_nettype wire

// ==== logic/bcr_ramp.sv ====
`default_nettype none
module bcr_ramp
	import bcr_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       channel_on,
	input  wire logic [7:0] target_code,
	input  wire logic [2:0] rise_change_slew,
	input  wire logic [2:0] fall_change_slew,
	input  wire logic [2:0] power_up_slew,
	input  wire logic [2:0] power_down_slew,
	output logic      [7:0] vout_code,
	output logic            regulating,
	output logic            ramping
);
	typedef enum logic [1:0] {
		RS_OFF  = 2'b00,
		RS_UP   = 2'b01,
		RS_ON   = 2'b10,
		RS_DOWN = 2'b11
	} bcr_rstate_t;

	typedef struct packed {
		bcr_rstate_t st;
		logic [7:0]  code;
		logic [8:0]  tick;
	} bcr_ramp_t;

	bcr_ramp_t q_ff;
	bcr_ramp_t nxt_q;

	// reserved codes fall back to the reset rate rather than stalling
	function automatic logic [2:0] legal(input logic [2:0] c,
		input logic [2:0] top);
		legal = (c > top) ? SLEW_RESET : c;
	endfunction

	function automatic logic [8:0] slew_cycles(input logic [2:0] c);
		case (c)
			3'h0: slew_cycles = CYC_8US;
			3'h1: slew_cycles = CYC_4US;
			3'h2: slew_cycles = CYC_2US;
			default: slew_cycles = CYC_1US;
		endcase
	endfunction

	// codes per step: 10, 20 or 40 mV
	function automatic logic [7:0] slew_step(input logic [2:0] c);
		case (c)
			3'h4: slew_step = 8'h02;
			3'h5: slew_step = 8'h04;
			default: slew_step = 8'h01;
		endcase
	endfunction

	// next ramp state: step toward goal, then sequence start-up/shut-down
	always_comb
	begin
		logic [7:0] goal;
		logic [2:0] rate;
		logic [7:0] step;
		logic [7:0] diff;
		logic       at_goal;
		nxt_q = q_ff;
		goal = (q_ff.st == RS_ON || q_ff.st == RS_UP) ? target_code : 8'h00;
		rate = SLEW_RESET;
		if (q_ff.st == RS_UP)
			rate = legal(power_up_slew, SLEW_TOP_RISE); // [RULE5]
		else if (q_ff.st == RS_DOWN)
			rate = legal(power_down_slew, SLEW_TOP_FALL); // [RULE4]
		else if (q_ff.code < goal)
			rate = legal(rise_change_slew, SLEW_TOP_RISE); // [RULE2] [RULE16]
		else
			rate = legal(fall_change_slew, SLEW_TOP_FALL); // [RULE1] [RULE16]
		step = slew_step(rate);
		at_goal = (q_ff.code == goal);
		diff = (q_ff.code < goal) ? goal - q_ff.code : q_ff.code - goal;
		if (at_goal || q_ff.st == RS_OFF)
			nxt_q.tick = 9'h000;
		else if (q_ff.tick >= slew_cycles(rate) - 9'h001)
		begin
			nxt_q.tick = 9'h000;
			if (q_ff.code < goal)
				nxt_q.code = q_ff.code + ((diff < step) ? diff : step);
			else
				nxt_q.code = q_ff.code - ((diff < step) ? diff : step);
		end
		else
			nxt_q.tick = q_ff.tick + 9'h001;
		unique case (q_ff.st)
			RS_OFF:
				if (channel_on)
					nxt_q.st = RS_UP; // [RULE3]
			RS_UP:
				if (!channel_on)
					nxt_q.st = RS_DOWN;
				else if (at_goal)
					nxt_q.st = RS_ON;
			RS_ON:
				if (!channel_on)
					nxt_q.st = RS_DOWN;
			RS_DOWN:
				if (channel_on)
					nxt_q.st = RS_UP;
				else if (at_goal)
					nxt_q.st = RS_OFF;
		endcase
		// immediate power-down skips the ramp entirely
		if (!channel_on && power_down_slew == SLEW_IMMEDIATE) // [RULE4]
		begin
			nxt_q.st = RS_OFF;
			nxt_q.code = 8'h00;
			nxt_q.tick = 9'h000;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			q_ff <= '{st: RS_OFF, code: 8'h00, tick: 9'h000};
		else
			q_ff <= nxt_q;
	end

	assign vout_code  = q_ff.code;
	assign regulating = (q_ff.st != RS_OFF);
	assign ramping    = (q_ff.st == RS_UP) || (q_ff.st == RS_DOWN) ||
		(q_ff.st == RS_ON && q_ff.code != target_code);

endmodule
`default_nettype wire

// ==== sim/bcr_channel_regs_monitor.sv ====
`default_nettype none
module bcr_channel_regs_chk
	import bcr_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_n,
	input wire logic       configuration_pin_pin_en,
	input wire bcr_configuration_pin_t  configuration_pin_init,
	input wire logic       channel_enable,
	input wire logic       regulating,
	input wire logic       ramping,
	input wire logic [7:0] vout_code,
	input wire logic       switch_node_pulldown,
	input wire bcr_mode_t  active_mode,
	input wire logic [3:0] overcurrent_threshold_code,
	input wire logic [7:0] ocp_limit_deci_amps,
	input wire logic       ocp_limit_off
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	chk_pulldown_while_on: assert property (
		regulating |-> !switch_node_pulldown)
		else $error("switch node pulled down while regulating");
	chk_ocp_off_code: assert property (
		ocp_limit_off == (overcurrent_threshold_code == 4'hf))
		else $error("limit-off flag does not match code");
	chk_ocp_scale: assert property (
		overcurrent_threshold_code inside {[4'h1:4'he]} |->
		ocp_limit_deci_amps == 8'h41 + 8'h0a *
		({4'h0, overcurrent_threshold_code} - 8'h01))
		else $error("threshold scale wrong");
	chk_mode_onehot: assert property (
		$onehot(active_mode))
		else $error("active mode not one-hot");
	chk_vout_range: assert property (
		vout_code <= 8'hbe)
		else $error("output code above top of range");
	// steps are at least 40 clocks apart, so eight quiet clocks must follow
	chk_step_gap: assert property (
		channel_enable && $changed(vout_code) |=>
		(!channel_enable || $stable(vout_code)) [*8])
		else $error("ramp steps too close together");
	chk_settled_hold: assert property (
		regulating && channel_enable && !ramping |=>
		$stable(vout_code) || !channel_enable)
		else $error("output moved while settled");
	chk_on_regulate: assert property (
		$rose(channel_enable) |-> ##[0:4] regulating)
		else $error("channel did not start after enable");
	chk_off_zero: assert property (
		!regulating |-> vout_code == 8'h00)
		else $error("output code not zero while off");
endmodule
bind bcr_channel_regs bcr_channel_regs_chk u_chk (.sys_clk, .rst_n,
	.scl_i, .sda_i, .sda_o, .sda_oe_n, .configuration_pin_pin_en, .configuration_pin_init,
	.channel_enable, .regulating, .ramping, .vout_code,
	.switch_node_pulldown, .active_mode, .overcurrent_threshold_code,
	.ocp_limit_deci_amps, .ocp_limit_off);
`default_nettype wire

// ==== sim/tb_top.sv ====
`default_nettype none
module tb_top
	import bcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] DEV = 7'h2a; // arbitrary bus address
	localparam logic [7:0] RST_TAB [7] = '{8'h48, 8'h48, 8'h09, 8'hbe,
		8'h0f, 8'h64, 8'h64};
	// address, written value, value read back
	localparam logic [23:0] WR_TAB [11] = '{24'h203a3a, 24'h217b7b,
		24'h220f0f, 24'h2300be, 24'h251d64, 24'h25bf64, 24'h251e1e,
		24'h25bebe, 24'h26c064, 24'h261e1e, 24'h241b1b};
	localparam logic [15:0] OCP_TAB [3] = '{16'h0141, 16'h0ec3, 16'h0f00};
	logic       sys_clk;
	logic       rst_n;
	logic       scl_i;
	logic       sda_m;
	logic       configuration_pin_pin_en;
	bcr_configuration_pin_t  configuration_pin_init;
	wire logic  sda_w;
	logic       sda_o;
	logic       sda_oe_n;
	logic       channel_enable;
	logic       regulating;
	logic       ramping;
	logic [7:0] vout_code;
	logic       switch_node_pulldown;
	bcr_mode_t  active_mode;
	logic [3:0] overcurrent_threshold_code;
	logic [7:0] ocp_limit_deci_amps;
	logic       ocp_limit_off;
	logic       ack;
	int         fail_count;
	int         samples_checked;
	int         waited;

	// open-drain data line: either party may pull it low
	assign sda_w = sda_m & (sda_oe_n | sda_o);

	bcr_channel_regs #(.DEV_ADDR(DEV)) uut (.sys_clk, .rst_n, .scl_i,
		.sda_i(sda_w), .sda_o, .sda_oe_n, .configuration_pin_pin_en, .configuration_pin_init,
		.channel_enable, .regulating, .ramping, .vout_code,
		.switch_node_pulldown, .active_mode, .overcurrent_threshold_code,
		.ocp_limit_deci_amps, .ocp_limit_off);

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic hc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// scl phases of 6+ clocks keep clear of the 3-flop synchroniser lag
	task automatic clk_bit(input logic b, output logic r);
		sda_m = b;
		hc(6);
		scl_i = 1'b1;
		hc(6);
		r = sda_w;
		scl_i = 1'b0;
		hc(2);
	endtask

	task automatic start_c;
		sda_m = 1'b1;
		hc(6);
		scl_i = 1'b1;
		hc(6);
		sda_m = 1'b0;
		hc(6);
		scl_i = 1'b0;
		hc(2);
	endtask

	task automatic stop_c;
		sda_m = 1'b0;
		hc(6);
		scl_i = 1'b1;
		hc(6);
		sda_m = 1'b1;
		hc(6);
	endtask

	task automatic tx(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], r);
		clk_bit(1'b1, ack);
	endtask

	// last byte of a read: master answers with no acknowledge
	task automatic rx(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(1'b1, r);
			d[i] = r;
		end
		clk_bit(1'b1, r);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		start_c;
		tx({DEV, 1'b0});
		tx(a);
		tx(d);
		stop_c;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		start_c;
		tx({DEV, 1'b0});
		tx(a);
		start_c;
		tx({DEV, 1'b1});
		rx(d);
		stop_c;
		chk(d, e);
	endtask

	task automatic do_reset;
		rst_n = 1'b0;
		hc(5);
		rst_n = 1'b1;
		hc(6);
	endtask

	// bounded wait for the ramp to settle on a code
	task automatic wait_v(input logic [7:0] e);
		waited = 0;
		while ((vout_code !== e || ramping !== 1'b0) && waited < 4000)
		begin
			hc(1);
			waited++;
		end
	endtask

	task automatic finish_test;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (80000) @(posedge sys_clk);
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test;
	end

	initial
	begin
		sda_m = 1'b1;
		scl_i = 1'b1;
		configuration_pin_pin_en = 1'b0;
		configuration_pin_init = '0;
		fail_count = 0;
		samples_checked = 0;
		do_reset;
		foreach (RST_TAB[i])
			rchk(8'h20 + 8'(i), RST_TAB[i]);
		$display("test reset values done");
		foreach (WR_TAB[i])
		begin
			wr(WR_TAB[i][23:16], WR_TAB[i][15:8]);
			rchk(WR_TAB[i][23:16], WR_TAB[i][7:0]);
		end
		$display("test write readback done");
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h24, 8'(4 * (3 - m) + m));
			chk({4'h0, active_mode}, 8'h08 >> m);
			wr(8'h24, 8'(16 + 4 * (3 - m) + m));
			chk({4'h0, active_mode}, 8'h08 >> (3 - m));
		end
		$display("test modes done");
		foreach (OCP_TAB[i])
		begin
			wr(8'h22, OCP_TAB[i][15:8]);
			chk(ocp_limit_deci_amps, OCP_TAB[i][7:0]);
			chk(8'(ocp_limit_off), 8'(OCP_TAB[i][15:8] == 8'h0f));
		end
		$display("test threshold done");
		wr(8'h25, 8'h40);
		wr(8'h24, 8'h03);
		wr(8'h21, 8'h7a);
		wr(8'h20, 8'h3b);
		chk(8'(channel_enable), 8'h01);
		wait_v(8'h40);
		chk(vout_code, 8'h40);
		chk(8'(switch_node_pulldown), 8'h00);
		// sixteen codes at one code per 40 clocks, started inside the write
		wr(8'h25, 8'h30);
		wait_v(8'h30);
		chk(vout_code, 8'h30);
		chk(8'(waited >= 560 && waited <= 640), 8'h01);
		wr(8'h20, 8'h3a);
		chk(vout_code, 8'h00);
		chk(8'(switch_node_pulldown), 8'h01);
		wr(8'h21, 8'h7b);
		chk(8'(switch_node_pulldown), 8'h00);
		$display("test ramp done");
		configuration_pin_pin_en = 1'b1;
		configuration_pin_init = '{channel_on: 1'b0, operating_point_select: 1'b1,
			point_b_mode: 2'h1, point_a_mode: 2'h2,
			point_a_voltage_code: 8'h50};
		do_reset;
		rchk(8'h24, 8'h16);
		rchk(8'h25, 8'h50);
		chk({4'h0, active_mode}, 8'h04);
		$display("test preload done");
		finish_test;
	end
endmodule
`default_nettype wire
